/* File: verilog/dpui_pkg.sv */
package dpui_pkg;
  // Clock and wait times
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_WAIT_US = 500;
  localparam int INIT_WAIT_CYC = (INIT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLLK_CYC = 1024;
  localparam int ZQINIT_CYC = 1024;
  // Mode register geometry
  localparam int MR_W = 14;
  localparam int MR_NUM = 7;
  localparam int MR_SEL_W = 3;
  // Default fields after reset
  localparam int MR3_GEARDOWN_BIT = 3;
  localparam int MR3_PDA_BIT = 4;
  localparam int MR4_MPS_BIT = 1;
  localparam int MR4_CAL_LSB = 6;
  localparam int MR4_CAL_MSB = 8;
  localparam int MR5_PAR_LSB = 0;
  localparam int MR5_PAR_MSB = 2;
  localparam logic MR3_GEARDOWN_RST = 1'h0;
  localparam logic MR3_PDA_RST = 1'h0;
  localparam logic MR4_MPS_RST = 1'h0;
  localparam logic [2:0] MR4_CAL_RST = 3'h0;
  localparam logic [2:0] MR5_PAR_RST = 3'h0;
  localparam logic [MR_W-1:0] MR_RST = 14'h0000;
  // Fields used by the sequence
  localparam int MR0_DLL_RESET_BIT = 8;
  localparam int MR1_RTT_LSB = 8;
  localparam int MR1_RTT_MSB = 10;
  localparam int ZQ_LONG_BIT = 10;
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MR0 = 8'h08;
  localparam logic [7:0] OFS_MR_LAST = 8'h20;
  localparam int CTRL_TERM_EN_BIT = 0;
  localparam logic CTRL_TERM_EN_RST = 1'h1;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_READY_BIT = 4;
  localparam int ST_HIZ_BIT = 5;
  localparam int ST_ERR_LSB = 8;
  localparam int ERR_W = 3;
  localparam int ERR_EARLY_CMD = 0;
  localparam int ERR_CKE_DROP = 1;
  localparam int ERR_TEN_HIGH = 2;
  typedef enum logic [2:0] {
    S_RESET = 3'h0,
    S_IWAIT = 3'h1,
    S_CKEWT = 3'h3,
    S_MRS = 3'h2,
    S_ZQ = 3'h6,
    S_READY = 3'h7
  } dpui_state_type;
endpackage

/* File: verilog/dpui_sync.sv */
`timescale 1ns/1ns
// Two-stage synchroniser for a bundle of pins
module dpui_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Only the second stage is visible to logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule

/* File: verilog/dpui_init.sv */
`timescale 1ns/1ns
module dpui_init
  import dpui_pkg::*;
#(
  parameter int INIT_CYC = INIT_WAIT_CYC,
  parameter int DLL_CYC = DLLK_CYC,
  parameter int ZQ_CYC = ZQINIT_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic ACT_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BG,
  input wire logic [1:0] BA,
  input wire logic [MR_W-1:0] A,
  input wire logic ODT,
  input wire logic TEN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic TERM_ON,
  output logic ODT_HIZ,
  output logic INIT_READY
);
  localparam int PIN_W = 13 + MR_W;
  localparam int ICW = $clog2(INIT_CYC + 1);
  localparam int DCW = $clog2(DLL_CYC + 1);
  localparam int ZCW = $clog2(ZQ_CYC + 1);
  // Pins idle as if reset is held and nothing is selected
  localparam logic [PIN_W-1:0] PIN_RST = {7'h1f, 4'h0, {MR_W{1'b0}}, 2'h0};

  logic [PIN_W-1:0] pins_s;
  logic rst_pin_n, cke_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s;
  logic [1:0] bg_s, ba_s;
  logic [MR_W-1:0] a_s;
  logic odt_s, ten_s;

  // Every pin crosses two flops before use
  dpui_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({RESET_N, CKE, CS_N, ACT_N, RAS_N, CAS_N, WE_N, BG, BA, A, ODT, TEN}),
    .q(pins_s)
  );
  assign {rst_pin_n, cke_s, cs_n_s, act_n_s, ras_n_s, cas_n_s, we_n_s,
          bg_s, ba_s, a_s, odt_s, ten_s} = pins_s;

  // Command decode, only while CKE is sampled high
  logic cmd_sel, mrs_cmd, zqcl_cmd;
  logic [MR_SEL_W-1:0] mr_sel;
  assign cmd_sel = cke_s & ~cs_n_s & act_n_s;
  assign mrs_cmd = cmd_sel & ~ras_n_s & ~cas_n_s & ~we_n_s;
  assign zqcl_cmd = cmd_sel & ras_n_s & cas_n_s & ~we_n_s & a_s[ZQ_LONG_BIT];
  assign mr_sel = {bg_s[0], ba_s};

  dpui_state_type state_ff, nxt_state;
  logic [ICW-1:0] init_cnt_ff, nxt_init_cnt;
  logic [DCW-1:0] dll_left_ff, nxt_dll_left;
  logic [ZCW-1:0] zq_left_ff, nxt_zq_left;
  logic dll_seen_ff, nxt_dll_seen;
  logic zq_seen_ff, nxt_zq_seen;
  logic [MR_W-1:0] mr_ff [MR_NUM];
  logic [MR_W-1:0] nxt_mr [MR_NUM];
  logic timers_done, in_config;

  assign timers_done = dll_seen_ff & zq_seen_ff & (dll_left_ff == '0) & (zq_left_ff == '0);
  assign in_config = (state_ff == S_MRS) | (state_ff == S_ZQ) | (state_ff == S_READY);

  // Sequence, mode registers and lock timers
  always_comb begin
    nxt_state = state_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_dll_left = dll_left_ff;
    nxt_zq_left = zq_left_ff;
    nxt_dll_seen = dll_seen_ff;
    nxt_zq_seen = zq_seen_ff;
    nxt_mr = mr_ff;
    if (dll_left_ff != '0) begin
      nxt_dll_left = dll_left_ff - DCW'(1);
    end
    if (zq_left_ff != '0) begin
      nxt_zq_left = zq_left_ff - ZCW'(1);
    end
    if (!rst_pin_n) begin
      // Other fields stay as they were; software must rewrite them anyway
      nxt_state = S_RESET;
      nxt_init_cnt = '0;
      nxt_dll_left = '0;
      nxt_zq_left = '0;
      nxt_dll_seen = 1'b0;
      nxt_zq_seen = 1'b0;
      nxt_mr[3][MR3_GEARDOWN_BIT] = MR3_GEARDOWN_RST;
      nxt_mr[3][MR3_PDA_BIT] = MR3_PDA_RST;
      nxt_mr[4][MR4_MPS_BIT] = MR4_MPS_RST;
      nxt_mr[4][MR4_CAL_MSB:MR4_CAL_LSB] = MR4_CAL_RST;
      nxt_mr[5][MR5_PAR_MSB:MR5_PAR_LSB] = MR5_PAR_RST;
    end else begin
      case (state_ff)
        S_RESET: begin
          nxt_state = S_IWAIT;
          nxt_init_cnt = '0;
        end
        S_IWAIT: begin
          // Paced by the internal clock only, the CK pins play no part
          if (init_cnt_ff == ICW'(INIT_CYC - 1)) begin
            nxt_state = S_CKEWT;
          end else begin
            nxt_init_cnt = init_cnt_ff + ICW'(1);
          end
        end
        S_CKEWT: begin
          if (cke_s) begin
            nxt_state = S_MRS;
          end
        end
        S_MRS: begin
          if (zqcl_cmd) begin
            nxt_state = S_ZQ;
          end
        end
        S_ZQ: begin
          if (timers_done) begin
            nxt_state = S_READY;
          end
        end
        S_READY: begin
          nxt_state = S_READY;
        end
        default: begin
          nxt_state = S_RESET;
        end
      endcase
      // Mode register loads and timer starts once configured
      if (in_config && mrs_cmd && mr_sel < MR_SEL_W'(MR_NUM)) begin
        nxt_mr[mr_sel] = a_s;
        if (mr_sel == '0 && a_s[MR0_DLL_RESET_BIT]) begin
          nxt_dll_left = DCW'(DLL_CYC);
          nxt_dll_seen = 1'b1;
        end
      end
      if (in_config && zqcl_cmd) begin
        nxt_zq_left = ZCW'(ZQ_CYC);
        nxt_zq_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_ff <= S_RESET;
      init_cnt_ff <= '0;
      dll_left_ff <= '0;
      zq_left_ff <= '0;
      dll_seen_ff <= 1'b0;
      zq_seen_ff <= 1'b0;
      for (int i = 0; i < MR_NUM; i++) begin
        mr_ff[i] <= MR_RST;
      end
    end else begin
      state_ff <= nxt_state;
      init_cnt_ff <= nxt_init_cnt;
      dll_left_ff <= nxt_dll_left;
      zq_left_ff <= nxt_zq_left;
      dll_seen_ff <= nxt_dll_seen;
      zq_seen_ff <= nxt_zq_seen;
      mr_ff <= nxt_mr;
    end
  end

  // Pin-facing outputs, registered from next values
  logic odt_hiz_ff, nxt_odt_hiz;
  logic term_on_ff, nxt_term_on;
  logic ready_ff, nxt_ready;
  logic ctrl_term_ff, nxt_ctrl_term;
  logic [ERR_W-1:0] err_ff, nxt_err;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [ERR_W-1:0] err_set;

  // Faults seen on the pins; these only report, never steer
  always_comb begin
    err_set = '0;
    err_set[ERR_EARLY_CMD] = rst_pin_n & ~in_config & cke_s & (mrs_cmd | zqcl_cmd);
    err_set[ERR_CKE_DROP] = rst_pin_n & ((state_ff == S_MRS) | (state_ff == S_ZQ)) & ~cke_s;
    err_set[ERR_TEN_HIGH] = ten_s & (state_ff != S_READY);
  end

  // Register bus, status flags and termination control
  always_comb begin
    nxt_odt_hiz = ~rst_pin_n | (nxt_state == S_RESET) | (nxt_state == S_IWAIT)
                | (nxt_state == S_CKEWT);
    // Termination needs RTT_NOM, the ODT pin and a software allow
    nxt_term_on = ~nxt_odt_hiz & ctrl_term_ff & odt_s
                & (nxt_mr[1][MR1_RTT_MSB:MR1_RTT_LSB] != 3'h0);
    nxt_ready = rst_pin_n & (nxt_state == S_READY);
    nxt_ctrl_term = ctrl_term_ff;
    nxt_err = err_ff;
    nxt_rdata = 32'h0000_0000;
    if (REG_WR) begin
      if (REG_ADDR == OFS_CTRL) begin
        nxt_ctrl_term = REG_WDATA[CTRL_TERM_EN_BIT];
      end else if (REG_ADDR == OFS_STATUS) begin
        nxt_err = err_ff & ~REG_WDATA[ST_ERR_LSB +: ERR_W];
      end
    end
    // A new fault in the clearing cycle stays set
    nxt_err = nxt_err | err_set;
    if (REG_RD) begin
      if (REG_ADDR == OFS_CTRL) begin
        nxt_rdata[CTRL_TERM_EN_BIT] = ctrl_term_ff;
      end else if (REG_ADDR == OFS_STATUS) begin
        nxt_rdata[ST_STATE_LSB +: 3] = state_ff;
        nxt_rdata[ST_READY_BIT] = ready_ff;
        nxt_rdata[ST_HIZ_BIT] = odt_hiz_ff;
        nxt_rdata[ST_ERR_LSB +: ERR_W] = err_ff;
      end else if (REG_ADDR >= OFS_MR0 && REG_ADDR <= OFS_MR_LAST && REG_ADDR[1:0] == 2'h0) begin
        nxt_rdata[MR_W-1:0] = mr_ff[3'((REG_ADDR - OFS_MR0) >> 2)];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      odt_hiz_ff <= 1'b1;
      term_on_ff <= 1'b0;
      ready_ff <= 1'b0;
      ctrl_term_ff <= CTRL_TERM_EN_RST;
      err_ff <= '0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      odt_hiz_ff <= nxt_odt_hiz;
      term_on_ff <= nxt_term_on;
      ready_ff <= nxt_ready;
      ctrl_term_ff <= nxt_ctrl_term;
      err_ff <= nxt_err;
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign TERM_ON = term_on_ff;
  assign ODT_HIZ = odt_hiz_ff;
  assign INIT_READY = ready_ff;

  // Checks on the sequence

  property p_mr_defaults;
    @(posedge REF_CLK) disable iff (RST)
    !rst_pin_n |=> (mr_ff[3][MR3_GEARDOWN_BIT] == 1'b0) && (mr_ff[3][MR3_PDA_BIT] == 1'b0)
      && (mr_ff[4][MR4_MPS_BIT] == 1'b0) && (mr_ff[4][8:6] == 3'h0) && (mr_ff[5][2:0] == 3'h0);
  endproperty
  a_mr_defaults: assert property (p_mr_defaults)
    else $error("mode register defaults not applied in reset");

  property p_init_span;
    @(posedge REF_CLK) disable iff (RST)
    (state_ff == S_CKEWT && $past(state_ff) == S_IWAIT)
      |-> $past(init_cnt_ff) == ICW'(INIT_CYC - 1);
  endproperty
  a_init_span: assert property (p_init_span)
    else $error("internal init left before its count");

  property p_init_hold;
    @(posedge REF_CLK) disable iff (RST)
    (state_ff == S_IWAIT && rst_pin_n && init_cnt_ff != ICW'(INIT_CYC - 1))
      |=> state_ff == S_IWAIT;
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("internal init cut short");

  property p_hiz_reset;
    @(posedge REF_CLK) disable iff (RST)
    !rst_pin_n |=> ODT_HIZ && !TERM_ON;
  endproperty
  a_hiz_reset: assert property (p_hiz_reset)
    else $error("termination active during reset");

  property p_hiz_release;
    @(posedge REF_CLK) disable iff (RST)
    // A fresh reset pulse may bring high-Z back at once
    (state_ff == S_CKEWT && cke_s && rst_pin_n)
      |=> !ODT_HIZ ##1 (!ODT_HIZ || $past(!rst_pin_n));
  endproperty
  a_hiz_release: assert property (p_hiz_release)
    else $error("termination not released after CKE high");

  property p_ready_cause;
    @(posedge REF_CLK) disable iff (RST)
    $rose(INIT_READY) |-> $past(timers_done) && $past(state_ff) == S_ZQ;
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready before lock and calibration times");

  property p_restart;
    @(posedge REF_CLK) disable iff (RST)
    (!rst_pin_n ##1 rst_pin_n) |=> state_ff == S_IWAIT && !INIT_READY;
  endproperty
  a_restart: assert property (p_restart)
    else $error("reset pulse did not restart the sequence");
endmodule

/* File: tb/dpui_ctrl_model.sv */
`timescale 1ns/1ns
// Controller side of the bring-up, behavioural
module dpui_ctrl_model
  import dpui_pkg::*;
#(
  parameter int INIT_CYC = 20,
  parameter int RST_CYC = 10,
  parameter int XPR_CYC = 5
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] gap,
  input wire logic [MR_NUM-1:0][MR_W-1:0] mr_vals,
  input wire logic ten_bad,
  output logic reset_n,
  output logic cke,
  output logic cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [MR_W-1:0] a,
  output logic odt,
  output logic ten
);
  // Load order, MR0 last so DLL enable in MR1 lands first
  localparam logic [20:0] ORD = {3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
  logic [2:0] sel;

  // Deselect slots; idle lines toggle so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      cs_n <= 1'b1;
      a <= ~a;
      {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
      @(posedge clk);
    end
  endtask

  task automatic cmd(input logic [2:0] rcw, input logic [2:0] s, input logic [MR_W-1:0] d);
    cs_n <= 1'b0;
    act_n <= 1'b1;
    {ras_n, cas_n, we_n} <= rcw;
    bg <= {1'b0, s[2]};
    ba <= s[1:0];
    a <= d;
    @(posedge clk);
  endtask

  initial begin
    {reset_n, cke, act_n, ras_n, cas_n, we_n, bg, ba, odt, ten} = '0;
    cs_n = 1'b1;
    a = 14'h0000;
  end

  // One full bring-up per go pulse; test enable raised only when ten_bad is set
  always begin
    @(posedge clk);
    if (go) begin
      cke <= 1'b0;
      reset_n <= 1'b0;
      odt <= 1'b0;
      // Fault injection: test enable high through the reset pulse
      ten <= ten_bad;
      idle(RST_CYC);
      reset_n <= 1'b1;
      ten <= 1'b0;
      idle(INIT_CYC + 4);
      cke <= 1'b1;
      idle(XPR_CYC + gap);
      for (int i = 0; i < 7; i++) begin
        sel = ORD[20-3*i -: 3];
        cmd(3'h0, sel, mr_vals[sel]);
        idle(gap);
      end
      cmd(3'h6, 3'h0, 14'h0400);
      idle(gap + DLLK_CYC / 64);
      odt <= 1'b1;
    end
  end
endmodule

/* File: tb/dpui_init_bench.sv */
`timescale 1ns/1ns
module dpui_init_bench;
  import dpui_pkg::*;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
  logic REF_CLK = 1'b0;
  logic rst = 1'b1;
  logic reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, odt, ten, go, bad;
  logic [1:0] bg, ba;
  logic [MR_W-1:0] a;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, d;
  logic reg_wr, reg_rd, term_on, odt_hiz, init_ready;
  logic [3:0] gap;
  logic [MR_NUM-1:0][MR_W-1:0] vals, prev;
  int fail_count = 0;
  int n_compared = 0;

  always #5 REF_CLK = ~REF_CLK;

  dpui_init #(.INIT_CYC(20), .DLL_CYC(8), .ZQ_CYC(8)) dut_u (
    .REF_CLK(REF_CLK), .RST(rst), .RESET_N(reset_n), .CKE(cke), .CS_N(cs_n),
    .ACT_N(act_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BG(bg), .BA(ba),
    .A(a), .ODT(odt), .TEN(ten), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TERM_ON(term_on),
    .ODT_HIZ(odt_hiz), .INIT_READY(init_ready));

  dpui_ctrl_model #(.INIT_CYC(20)) mdl_u (
    .clk(REF_CLK), .go(go), .gap(gap), .mr_vals(vals), .reset_n(reset_n),
    .cke(cke), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bg(bg), .ba(ba), .a(a), .odt(odt), .ten(ten), .ten_bad(bad));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Status word built from the field positions
  function automatic logic [31:0] st_exp(input logic [2:0] s, input logic rdy,
                                         input logic hz, input logic [ERR_W-1:0] er);
    logic [31:0] v;
    v = 32'h0;
    v[ST_STATE_LSB +: 3] = s;
    v[ST_READY_BIT] = rdy;
    v[ST_HIZ_BIT] = hz;
    v[ST_ERR_LSB +: ERR_W] = er;
    return v;
  endfunction

  // Single-cycle strobes; read data sampled in the cycle after
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge REF_CLK);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge REF_CLK);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
    @(posedge REF_CLK);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge REF_CLK);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence: power-on then two stable-power resets
  initial begin
    {go, bad, reg_wr, reg_rd} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    gap = 4'h1;
    seed = 32'h15a1;
    vals = '0;
    repeat (6) @(posedge REF_CLK);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h1, "ctrl");
    rd(OFS_STATUS, 32'h20, "status");
    rd(8'hfc, 32'h0, "unmapped");
    for (int r = 0; r < 3; r++) begin
      prev = vals;
      for (int k = 0; k < MR_NUM; k++) begin
        seed = lfsr(lfsr(seed));
        vals[k] = seed[13:0];
      end
      vals[1][0] = 1'b1;
      vals[1][8] = 1'b1;
      vals[0][8] = 1'b1;
      gap <= (r == 0) ? 4'h1 : {1'b0, seed[18:16]} + 4'h2;
      bad <= (r == 2);
      go <= 1'b1;
      @(posedge REF_CLK);
      go <= 1'b0;
      if (r > 0) begin
        // Reset clears only the unsafe fields
        repeat (4) @(posedge REF_CLK);
        rd(OFS_MR0 + 8'hc, {18'h0, prev[3] & 14'h3fe7}, "mr3 dflt");
        rd(OFS_MR0 + 8'h10, {18'h0, prev[4] & 14'h3e3d}, "mr4 dflt");
        rd(OFS_MR0 + 8'h14, {18'h0, prev[5] & 14'h3ff8}, "mr5 dflt");
        `CHK("hiz in reset", 1'b1, odt_hiz)
        `CHK("term in reset", 1'b0, term_on)
        if (bad) begin
          // Test enable raised in reset: flag seen, then write-one-to-clear
          rd(OFS_STATUS, st_exp(S_RESET, 1'b0, 1'b1, 3'(1 << ERR_TEN_HIGH)), "ten flag");
          wr(OFS_STATUS, 32'h1 << (ST_ERR_LSB + ERR_TEN_HIGH));
          rd(OFS_STATUS, st_exp(S_IWAIT, 1'b0, 1'b1, 3'h0), "ten cleared");
        end
      end
      // Bounded wait for the end of bring-up
      for (int i = 0; i <= 2000; i++) begin
        @(posedge REF_CLK);
        #1;
        if (init_ready === 1'b1) break;
        if (i == 2000) begin
          fail_count++;
          $display("unexpected ready timeout");
          end_of_test();
        end
      end
      rd(OFS_STATUS, 32'h17, "status ready");
      for (int k = 0; k < MR_NUM; k++) begin
        rd(OFS_MR0 + 8'(4 * k), {18'h0, vals[k]}, "mr");
      end
      // Late ODT rise from the model needs two sync stages and a register
      repeat (2) @(posedge REF_CLK);
      #1;
      `CHK("term on", 1'b1, term_on)
      wr(OFS_CTRL, 32'h0);
      repeat (2) @(posedge REF_CLK);
      #1;
      `CHK("term off", 1'b0, term_on)
      wr(OFS_CTRL, 32'h1);
      rd(OFS_CTRL, 32'h1, "ctrl back");
    end
    end_of_test();
  end
endmodule
